// [tka_bank.sv]
// Touch and ADC configuration register bank with conversion control.
//
// How it works
// - Eight touch enables, reset zero, one connects.
// - Touch count split high nibble, low byte.
// - Bits 7-6 select touch module type.
// - Write-only bit 3 picks regulator voltage.
// - Write-only bit 2 picks touch supply.
// - ADC control bit 7 enables the ADC.
// - Bit 6 reads one when ADC ready.
// - Bits 5-2 select the conversion input.
// - Clock mode divides system clock by 2^n.
// - Result high byte, low register upper nibble.
`timescale 1ns/100ps
module tka_bank
    import tka_pkg::*;
(
    input  wire logic                 ref_clk,       // System clock, 50 MHz.
    input  wire logic                 rst_b,         // Asynchronous reset, active low.
    input  wire logic [7:0]           reg_addr,      // Register address.
    input  wire logic [7:0]           reg_wdata,     // Write data.
    input  wire logic                 reg_wr,        // Write strobe.
    input  wire logic                 reg_rd,        // Read strobe.
    output logic      [7:0]           reg_rdata,     // Read data, one cycle later.
    input  wire logic                 touch_busy,    // Touch measurement running.
    input  wire logic [TKA_CNT_W-1:0] touch_count,   // Touch charge counter.
    input  wire logic                 adc_done,      // Analog conversion finished.
    input  wire logic [TKA_CNT_W-1:0] adc_value,     // Analog conversion value.
    output logic      [7:0]           touch_enable,  // Pin to touch unit connects.
    output logic      [1:0]           touch_type,    // Touch module type.
    output logic      [1:0]           touch_vref_mode, // Reference voltage mode.
    output logic                      regulator_2v,  // Regulator at 2 V, else 2.4 V.
    output logic                      touch_supply_from_regulator, // Else VDD.
    output logic                      bandgap_low_voltage_detect_off, // Detector off.
    output logic                      adc_enable,    // ADC powered.
    output logic      [3:0]           adc_channel,   // Conversion input select.
    output logic                      adc_convert,   // Conversion in progress.
    output logic                      adc_clk_en,    // ADC clock enable pulse.
    output logic                      irq            // Level interrupt.
);

    // ------------------------------------------------------------------
    // State.
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]           tch_en;  // Touch channel enables.
        logic [7:0]           tparam;  // Reserved touch parameter byte.
        logic [7:0]           ttype;   // Touch type and reference mode byte.
        logic [7:0]           pwr;     // Touch power option byte.
        logic                 adc_en;  // ADC enable.
        logic [3:0]           adc_ch;  // ADC channel selector.
        logic [2:0]           div_sel; // ADC clock divider code.
        tka_adc_e             adc_st;  // Conversion sequencer.
        logic [TKA_CNT_W-1:0] result;  // Last conversion result.
        logic [TKA_CNT_W-1:0] tcount;  // Held touch count.
        logic [2:0]           busy_s;  // Synchroniser for touch busy.
        logic [2:0]           done_s;  // Synchroniser for conversion done.
        logic                 busy_l;  // Accepted touch busy level.
        logic                 done_l;  // Accepted conversion done level.
        logic [TKA_NEV-1:0]   status;  // Sticky event bits.
        logic [TKA_NEV-1:0]   mask;    // Event enables.
        logic                 irq;     // Registered interrupt.
        logic                 clk_en;  // Registered ADC clock enable.
        logic                 conv;    // Registered conversion-in-progress flag.
        logic [7:0]           rdata;   // Read data.
    } tka_top_s;

    tka_top_s st_r;   // Current state.
    tka_top_s st_nxt; // Next state.

    logic [TKA_NEV-1:0] ev_set; // Events raised this cycle.
    logic [TKA_NEV-1:0] ev_clr; // Bits software clears this cycle.
    logic               wr_hit; // Write strobe, taken unqualified.

    tka_div_if div_bus (); // Link to the clock divider.

    // ------------------------------------------------------------------
    // ADC clock divider.
    // ------------------------------------------------------------------

    // Divider runs only while the ADC is enabled.
    assign div_bus.div_sel = st_r.div_sel;
    assign div_bus.run     = st_r.adc_en;

    tka_adc_clkdiv u_div (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .dv      (div_bus.div)
    );

    // ------------------------------------------------------------------
    // Next state.
    // ------------------------------------------------------------------

    // Computes pin synchronisers, register writes, the sequencer and reads.
    always_comb
    begin
        st_nxt       = st_r;
        ev_set       = '0;
        ev_clr       = '0;
        wr_hit       = reg_wr;
        st_nxt.rdata = TKA_ZERO_BYTE;
        st_nxt.clk_en = div_bus.tick;

        // Three-stage synchronisers; only stages two and three are compared.
        st_nxt.busy_s = {st_r.busy_s[1:0], touch_busy};
        st_nxt.done_s = {st_r.done_s[1:0], adc_done};
        if (st_r.busy_s[1] == st_r.busy_s[2])
        begin
            st_nxt.busy_l = st_r.busy_s[2];
        end
        if (st_r.done_s[1] == st_r.done_s[2])
        begin
            st_nxt.done_l = st_r.done_s[2];
        end

        // A measurement has ended: freeze its count for reads.
        if (st_r.busy_l && !st_nxt.busy_l)
        begin
            st_nxt.tcount        = touch_count;
            ev_set[TKA_EV_TOUCH] = 1'b1;
        end

        // Register writes.
        if (wr_hit)
        begin
            case (reg_addr)
                TKA_OFF_TCH_EN:
                begin
                    st_nxt.tch_en = reg_wdata;
                end
                TKA_OFF_TPARAM:
                begin
                    st_nxt.tparam = reg_wdata;
                end
                TKA_OFF_TTYPE:
                begin
                    st_nxt.ttype = reg_wdata;
                end
                TKA_OFF_PWR:
                begin
                    st_nxt.pwr = reg_wdata;
                end
                TKA_OFF_ADC_CTL:
                begin
                    st_nxt.adc_en = reg_wdata[TKA_ADC_EN];
                    st_nxt.adc_ch = reg_wdata[TKA_CH_MSB:TKA_CH_LSB];
                end
                TKA_OFF_ADC_MODE:
                begin
                    st_nxt.div_sel = reg_wdata[TKA_DIV_MSB:TKA_DIV_LSB];
                end
                TKA_OFF_IRQ_STS:
                begin
                    ev_clr = reg_wdata[TKA_NEV-1:0];
                end
                TKA_OFF_IRQ_MSK:
                begin
                    st_nxt.mask = reg_wdata[TKA_NEV-1:0];
                end
                default:
                begin
                    // Unmapped or read-only offset: write ignored.
                end
            endcase
        end

        // Conversion sequencer.
        case (st_r.adc_st)
            TKA_ADC_IDLE:
            begin
                // A start needs the enable in the same write.
                if (wr_hit && reg_addr == TKA_OFF_ADC_CTL
                    && reg_wdata[TKA_ADC_GO] && reg_wdata[TKA_ADC_EN])
                begin
                    st_nxt.adc_st = TKA_ADC_CONV;
                end
            end
            TKA_ADC_CONV:
            begin
                if (!st_nxt.adc_en)
                begin
                    // Disabling the ADC abandons the conversion.
                    st_nxt.adc_st = TKA_ADC_IDLE;
                end
                else if (st_r.done_l == 1'b0 && st_nxt.done_l == 1'b1)
                begin
                    st_nxt.adc_st = TKA_ADC_LATCH;
                end
            end
            TKA_ADC_LATCH:
            begin
                // Result lands on the same edge that ready rises again.
                st_nxt.result      = adc_value;
                ev_set[TKA_EV_ADC] = 1'b1;
                st_nxt.adc_st      = TKA_ADC_IDLE;
            end
            default:
            begin
                st_nxt.adc_st = TKA_ADC_IDLE;
            end
        endcase

        // Conversion flag kept in its own flop so the output needs no decode.
        st_nxt.conv = (st_nxt.adc_st == TKA_ADC_CONV) ? 1'b1 : 1'b0;

        // Sticky events; a new event wins over a clear in the same cycle.
        st_nxt.status = (st_r.status & ~ev_clr) | ev_set;
        st_nxt.irq    = |(st_nxt.status & st_nxt.mask);

        // Read data, presented the cycle after the strobe only.
        if (reg_rd)
        begin
            case (reg_addr)
                TKA_OFF_TCH_EN:
                begin
                    st_nxt.rdata = st_r.tch_en;
                end
                TKA_OFF_TPARAM:
                begin
                    st_nxt.rdata = st_r.tparam;
                end
                TKA_OFF_TTYPE:
                begin
                    st_nxt.rdata = st_r.ttype;
                end
                TKA_OFF_ADC_CTL:
                begin
                    // Reserved low bits read zero.
                    st_nxt.rdata[TKA_ADC_EN]              = st_r.adc_en;
                    st_nxt.rdata[TKA_ADC_GO]              = (st_r.adc_st == TKA_ADC_IDLE);
                    st_nxt.rdata[TKA_CH_MSB:TKA_CH_LSB]   = st_r.adc_ch;
                end
                TKA_OFF_CNT_HI:
                begin
                    // Upper nibble reserved, reads zero.
                    st_nxt.rdata[3:0] = st_r.tcount[TKA_CNT_W-1:8];
                end
                TKA_OFF_CNT_LO:
                begin
                    st_nxt.rdata = st_r.tcount[7:0];
                end
                TKA_OFF_RES_HI:
                begin
                    st_nxt.rdata = st_r.result[TKA_CNT_W-1:4];
                end
                TKA_OFF_RES_LO:
                begin
                    st_nxt.rdata[7:4] = st_r.result[3:0];
                end
                TKA_OFF_IRQ_STS:
                begin
                    st_nxt.rdata[TKA_NEV-1:0] = st_r.status;
                end
                TKA_OFF_IRQ_MSK:
                begin
                    st_nxt.rdata[TKA_NEV-1:0] = st_r.mask;
                end
                default:
                begin
                    // Write-only and unmapped offsets read zero.
                    st_nxt.rdata = TKA_ZERO_BYTE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // State register.
    // ------------------------------------------------------------------

    // Every field resets to zero, which is also the idle sequencer state.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    // ------------------------------------------------------------------
    // Outputs, each straight from the state register.
    // ------------------------------------------------------------------
    assign reg_rdata                      = st_r.rdata;
    assign touch_enable                   = st_r.tch_en;
    assign touch_type                     = st_r.ttype[TKA_TYPE_LSB+1:TKA_TYPE_LSB];
    assign touch_vref_mode                = st_r.ttype[TKA_VREF_MSB:0];
    assign regulator_2v                   = st_r.pwr[TKA_PWR_VSEL];
    assign touch_supply_from_regulator    = st_r.pwr[TKA_PWR_TSUP];
    assign bandgap_low_voltage_detect_off = st_r.pwr[TKA_PWR_BGOFF];
    assign adc_enable                     = st_r.adc_en;
    assign adc_channel                    = st_r.adc_ch;
    assign adc_convert                    = st_r.conv;
    assign adc_clk_en                     = st_r.clk_en;
    assign irq                            = st_r.irq;

endmodule : tka_bank

// [tka_pkg.sv]
// Shared constants and types for the touch and ADC configuration bank.
package tka_pkg;

    // ------------------------------------------------------------------
    // Register offsets.
    // ------------------------------------------------------------------
    localparam logic [7:0] TKA_OFF_PWR      = 8'h0A; // Touch power option, write-only.
    localparam logic [7:0] TKA_OFF_ADC_CTL  = 8'h3B; // ADC control.
    localparam logic [7:0] TKA_OFF_ADC_MODE = 8'h3C; // ADC clock mode, write-only.
    localparam logic [7:0] TKA_OFF_RES_HI   = 8'h3E; // ADC result high byte.
    localparam logic [7:0] TKA_OFF_RES_LO   = 8'h3F; // ADC result low nibble.
    localparam logic [7:0] TKA_OFF_TCH_EN   = 8'h45; // Touch channel enables 0 to 7.
    localparam logic [7:0] TKA_OFF_TPARAM   = 8'h46; // Reserved touch parameters.
    localparam logic [7:0] TKA_OFF_TTYPE    = 8'h47; // Touch type and reference mode.
    localparam logic [7:0] TKA_OFF_CNT_HI   = 8'h48; // Touch count bits 11 to 8.
    localparam logic [7:0] TKA_OFF_CNT_LO   = 8'h49; // Touch count bits 7 to 0.
    localparam logic [7:0] TKA_OFF_IRQ_STS  = 8'h4A; // Event status, write one to clear.
    localparam logic [7:0] TKA_OFF_IRQ_MSK  = 8'h4B; // Event mask.

    // ------------------------------------------------------------------
    // Field positions.
    // ------------------------------------------------------------------
    localparam int TKA_PWR_VSEL  = 3; // Regulator voltage: 0 gives 2.4 V, 1 gives 2 V.
    localparam int TKA_PWR_TSUP  = 2; // Touch supply: 0 from VDD, 1 from regulator.
    localparam int TKA_PWR_BGOFF = 0; // Bandgap low voltage detect power off.
    localparam int TKA_ADC_EN    = 7; // ADC enable.
    localparam int TKA_ADC_GO    = 6; // Start on write, ready on read.
    localparam int TKA_CH_LSB    = 2; // Channel selector low bit.
    localparam int TKA_CH_MSB    = 5; // Channel selector high bit.
    localparam int TKA_DIV_LSB   = 1; // Clock divider code low bit.
    localparam int TKA_DIV_MSB   = 3; // Clock divider code high bit.
    localparam int TKA_TYPE_LSB  = 6; // Touch module type low bit.
    localparam int TKA_VREF_MSB  = 1; // Reference mode high bit.
    localparam int TKA_EV_TOUCH  = 0; // Touch measurement finished.
    localparam int TKA_EV_ADC    = 1; // ADC conversion finished.

    // ------------------------------------------------------------------
    // Widths and reset values.
    // ------------------------------------------------------------------
    localparam int         TKA_NEV       = 2;     // Number of interrupt events.
    localparam int         TKA_CNT_W     = 12;    // Touch count and ADC result width.
    localparam int         TKA_DIV_W     = 7;     // Divider counter width, up to 128.
    localparam logic [7:0] TKA_ZERO_BYTE = 8'h00; // Reset value of every register except ADC control, which reads 8'h40.

    // ADC conversion sequencer states, Gray coded from idle to latch; latch back to idle flips both bits.
    typedef enum logic [1:0] {
        TKA_ADC_IDLE  = 2'b00,
        TKA_ADC_CONV  = 2'b01,
        TKA_ADC_LATCH = 2'b11
    } tka_adc_e;

    // Terminal count of the ADC clock divider for a divider code.
    function automatic logic [TKA_DIV_W-1:0] tka_div_limit(input logic [2:0] code);
        logic [TKA_DIV_W:0] full;
        full = (TKA_DIV_W+1)'(1) << code;
        return TKA_DIV_W'(full - (TKA_DIV_W+1)'(1));
    endfunction : tka_div_limit

endpackage : tka_pkg

// [tka_div_if.sv]
// Carrier between the bank and its ADC clock divider.
`timescale 1ns/100ps
interface tka_div_if;
    logic [2:0] div_sel; // Divider code, divide by two to its power.
    logic       run;     // Divider runs while the ADC is enabled.
    logic       tick;    // One-cycle ADC clock enable.

    // Bank side.
    modport ctrl (output div_sel, output run, input tick);
    // Divider side.
    modport div (input div_sel, input run, output tick);
endinterface : tka_div_if

// [tka_adc_clkdiv.sv]
// ADC clock divider making a one-cycle enable from the system clock.
`timescale 1ns/100ps
module tka_adc_clkdiv
    import tka_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    tka_div_if.div   dv
);

    // ------------------------------------------------------------------
    // State.
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [TKA_DIV_W-1:0] cnt;  // Cycles since the last tick.
        logic                 tick; // Registered enable pulse.
    } tka_div_s;

    tka_div_s st_r;   // Current state.
    tka_div_s st_nxt; // Next state.

    // Counts up to the terminal value of the code, then ticks once.
    always_comb
    begin
        st_nxt      = st_r;
        st_nxt.tick = 1'b0;
        if (!dv.run)
        begin
            // Held at zero while the ADC is off.
            st_nxt.cnt = '0;
        end
        else if (st_r.cnt >= tka_div_limit(dv.div_sel))
        begin
            // Terminal count reached: pulse and restart.
            st_nxt.cnt  = '0;
            st_nxt.tick = 1'b1;
        end
        else
        begin
            st_nxt.cnt = st_r.cnt + TKA_DIV_W'(1);
        end
    end

    // Registers the state.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign dv.tick = st_r.tick;

endmodule : tka_adc_clkdiv

// [tka_bank_checker.sv]
// Port-level assertions for the touch and ADC register bank.
`timescale 1ns/100ps
module tka_bank_checker
    import tka_pkg::*;
(
    input wire logic       ref_clk,
    input wire logic       rst_b,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] touch_enable,
    input wire logic [1:0] touch_type,
    input wire logic [1:0] touch_vref_mode,
    input wire logic       regulator_2v,
    input wire logic       touch_supply_from_regulator,
    input wire logic       adc_enable,
    input wire logic [3:0] adc_channel,
    input wire logic       adc_convert,
    input wire logic       adc_clk_en,
    input wire logic       irq
);
    // ----------------------------------------
    // Write and read decodes shared by the properties.
    // ----------------------------------------
    wire logic w_tch = reg_wr && reg_addr == TKA_OFF_TCH_EN;   // Touch enable write.
    wire logic w_typ = reg_wr && reg_addr == TKA_OFF_TTYPE;    // Type register write.
    wire logic w_pwr = reg_wr && reg_addr == TKA_OFF_PWR;      // Power option write.
    wire logic w_adc = reg_wr && reg_addr == TKA_OFF_ADC_CTL;  // ADC control write.
    wire logic r_wo  = reg_rd && (reg_addr == TKA_OFF_PWR || reg_addr == TKA_OFF_ADC_MODE); // Write-only read.

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    // ----------------------------------------
    // Assertions and covers.
    // ----------------------------------------
    chk_tch_en_write: assert property (w_tch |=> touch_enable == $past(reg_wdata))
        else $error("touch enables do not follow the write");
    chk_type_write: assert property (w_typ |=> touch_type == $past(reg_wdata[7:6])
        && touch_vref_mode == $past(reg_wdata[1:0])) else $error("touch type field wrong");
    chk_pwr_vsel: assert property (w_pwr |=> regulator_2v == $past(reg_wdata[3]))
        else $error("regulator voltage select wrong");
    chk_pwr_tsup: assert property (w_pwr |=> touch_supply_from_regulator == $past(reg_wdata[2]))
        else $error("touch supply select wrong");
    chk_adc_enable: assert property (w_adc |=> adc_enable == $past(reg_wdata[7]))
        else $error("adc enable wrong");
    chk_adc_channel: assert property (w_adc |=> adc_channel == $past(reg_wdata[5:2]))
        else $error("adc channel wrong");
    chk_conv_start: assert property ($rose(adc_convert) |-> $past(w_adc && reg_wdata[7] && reg_wdata[6]))
        else $error("conversion started without a start write");
    chk_busy_ready: assert property (reg_rd && reg_addr == TKA_OFF_ADC_CTL && adc_convert
        |=> reg_rdata[6] == 1'b0 && reg_rdata[1:0] == 2'b00) else $error("ready shown while converting");
    chk_wo_reads: assert property (r_wo |=> reg_rdata == 8'h00)
        else $error("write-only register read not zero");
    chk_clk_quiet: assert property (!adc_enable && !$past(adc_enable) && !$past(adc_enable, 2)
        |-> !adc_clk_en) else $error("adc clock runs while disabled");
    cov_conv: cover property ($rose(adc_convert));
    cov_irq: cover property ($rose(irq));
    cov_clk: cover property (adc_clk_en);
endmodule : tka_bank_checker

bind tka_bank tka_bank_checker u_chk (.*);

// [tb_top.sv]
// Self-checking bench for the touch and ADC register bank.
`timescale 1ns/100ps
module tb_top
    import tka_pkg::*;
;
    // ----------------------------------------
    // Stimulus, observed outputs and counters.
    // ----------------------------------------
    logic        ref_clk, rst_b, reg_wr, reg_rd, touch_busy, adc_done;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, touch_enable;
    logic [11:0] touch_count, adc_value;
    logic [1:0]  touch_type, touch_vref_mode;
    logic        regulator_2v, touch_supply_from_regulator, bandgap_low_voltage_detect_off;
    logic        adc_enable, adc_convert, adc_clk_en, irq;
    logic [3:0]  adc_channel;
    int          failures, checked, cycles;
    logic [3:0]  chans[12] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hF}; // Codes 0 to A and F.
    logic [7:0]  rst_off[5] = '{TKA_OFF_TCH_EN, TKA_OFF_ADC_CTL, TKA_OFF_TPARAM, TKA_OFF_CNT_HI, TKA_OFF_CNT_LO};
    logic [7:0]  rst_exp[5] = '{8'h00, 8'h40, 8'h00, 8'h00, 8'h00}; // Ready reads one when idle.

    tka_bank u_dut (.*);

    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // Cuts a hung run short.
    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            failures++;
            wrap_up();
        end
    end

    // ----------------------------------------
    // Bus tasks and comparison.
    // ----------------------------------------
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // One-cycle write; returns just after the edge that takes it.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr

    // One-cycle read; the data stand only in the following cycle.
    task automatic rc(input string nm, input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk(nm, e, reg_rdata);
    endtask : rc

    // The interrupt output is registered, so look one edge later.
    task automatic irq_is(input logic e);
        @(posedge ref_clk) #1;
        chk("irq", {7'h0, e}, {7'h0, irq});
    endtask : irq_is

    // Measures the spacing of two clock enable pulses.
    task automatic gap(input int c);
        int n;
        for (n = 0; n < 300 && adc_clk_en !== 1'b1; n++) @(posedge ref_clk) #1;
        @(posedge ref_clk) #1;
        for (n = 1; n < 300 && adc_clk_en !== 1'b1; n++) @(posedge ref_clk) #1;
        chk("adc clock gap", 8'(1 << c), 8'(n));
    endtask : gap

    task automatic wrap_up;
        $display("checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : wrap_up

    // ----------------------------------------
    // Test sequence.
    // ----------------------------------------
    initial
    begin
        {rst_b, reg_wr, reg_rd, touch_busy, adc_done, reg_addr, reg_wdata} = '0;
        touch_count = 12'h5A3;
        adc_value   = 12'hABC;
        repeat (3) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk) #1;
        chk("outputs", 8'h00, {touch_type, touch_vref_mode, regulator_2v, touch_supply_from_regulator,
            adc_enable, irq});
        chk("enables", 8'h00, touch_enable);
        chk("adc outputs", 8'h00, {adc_channel, adc_convert, adc_clk_en, bandgap_low_voltage_detect_off, 1'b0});
        foreach (rst_off[i]) rc("reset value", rst_off[i], rst_exp[i]);
        wr(TKA_OFF_ADC_CTL, 8'h14);
        for (int i = 0; i < 9; i++)
        begin
            wr(TKA_OFF_TCH_EN, 8'(i < 8 ? 1 << i : 8'hA5));
            chk("touch enable", 8'(i < 8 ? 1 << i : 8'hA5), touch_enable);
            rc("enable readback", TKA_OFF_TCH_EN, 8'(i < 8 ? 1 << i : 8'hA5));
        end
        wr(TKA_OFF_TCH_EN, 8'h00);
        wr(TKA_OFF_TPARAM, 8'h00);
        rc("param", TKA_OFF_TPARAM, 8'h00);
        // Bypass pairing first, then regulator pairing.
        for (int i = 0; i < 2; i++)
        begin
            wr(TKA_OFF_PWR, i ? 8'h0D : 8'h00);
            wr(TKA_OFF_TTYPE, i ? 8'h41 : 8'h01);
            chk("supply and type", i ? 8'h75 : 8'h01, {1'b0, bandgap_low_voltage_detect_off, regulator_2v,
                touch_supply_from_regulator, touch_type, touch_vref_mode});
            rc("power reads", TKA_OFF_PWR, 8'h00);
            rc("type readback", TKA_OFF_TTYPE, i ? 8'h41 : 8'h01);
        end
        foreach (chans[i])
        begin
            wr(TKA_OFF_ADC_CTL, {2'b00, chans[i], 2'b00});
            chk("adc channel", {4'h0, chans[i]}, {4'h0, adc_channel});
            rc("adc control", TKA_OFF_ADC_CTL, {2'b01, chans[i], 2'b00});
        end
        for (int c = 0; c < 8; c++)
        begin
            wr(TKA_OFF_ADC_CTL, 8'h14);
            wr(TKA_OFF_ADC_MODE, 8'(c << 1));
            wr(TKA_OFF_ADC_CTL, 8'h94);
            gap(c);
        end
        rc("mode reads", TKA_OFF_ADC_MODE, 8'h00);
        wr(TKA_OFF_ADC_CTL, 8'h54);
        chk("start refused", 8'h00, {7'h0, adc_convert});
        wr(TKA_OFF_ADC_CTL, 8'hD4);
        chk("converting", 8'h01, {7'h0, adc_convert});
        rc("busy reads", TKA_OFF_ADC_CTL, 8'h94);
        @(posedge ref_clk) adc_done <= 1'b1;
        for (int n = 0; n < 20 && adc_convert === 1'b1; n++) @(posedge ref_clk) #1;
        repeat (3) @(posedge ref_clk);
        rc("result high", TKA_OFF_RES_HI, 8'hAB);
        rc("result low", TKA_OFF_RES_LO, 8'hC0);
        rc("ready again", TKA_OFF_ADC_CTL, 8'hD4);
        rc("adc event", TKA_OFF_IRQ_STS, 8'h02);
        irq_is(1'b0);
        wr(TKA_OFF_IRQ_MSK, 8'h02);
        irq_is(1'b1);
        wr(TKA_OFF_IRQ_STS, 8'h02);
        irq_is(1'b0);
        @(posedge ref_clk) adc_done <= 1'b0;
        // Clearing the enable mid-conversion aborts without an event.
        wr(TKA_OFF_ADC_CTL, 8'hD4);
        wr(TKA_OFF_ADC_CTL, 8'h14);
        chk("aborted", 8'h00, {7'h0, adc_convert});
        rc("no event", TKA_OFF_IRQ_STS, 8'h00);
        // The measurement runs in the regulator pairing, which has no clock limit.
        @(posedge ref_clk) touch_busy <= 1'b1;
        repeat (5) @(posedge ref_clk);
        touch_busy <= 1'b0;
        repeat (6) @(posedge ref_clk);
        touch_count <= 12'hFFF;
        rc("count high", TKA_OFF_CNT_HI, 8'h05);
        rc("count low", TKA_OFF_CNT_LO, 8'hA3);
        wr(TKA_OFF_CNT_LO, 8'h11);
        rc("count kept", TKA_OFF_CNT_LO, 8'hA3);
        rc("touch event", TKA_OFF_IRQ_STS, 8'h01);
        wr(TKA_OFF_IRQ_MSK, 8'h01);
        irq_is(1'b1);
        wr(TKA_OFF_IRQ_STS, 8'h01);
        irq_is(1'b0);
        rc("unmapped", 8'h50, 8'h00);
        wrap_up();
    end
endmodule : tb_top
